// ==== hw/rcs_pkg.sv ====
// Purpose: Constants for the reset configuration sequencer
// Assumes: 100 MHz core clock
// Notes:   Counts are in core clock cycles unless named per input clock
package rcs_pkg;
	localparam int unsigned CLK_PERIOD_NS     = 10;
	localparam int unsigned HRST_IN_MIN_PER   = 32;
	localparam int unsigned POR_MIN_PER       = 32;
	localparam int unsigned HRST_OUT_MIN_PER  = 512;
	localparam int unsigned STRAP_SETUP_PER   = 4;
	localparam int unsigned DRIVE_RESUME_PER  = 1;
	localparam int unsigned PLL_LOCK_US       = 100;
	localparam int unsigned PLL_LOCK_CYC      = (PLL_LOCK_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned NUM_PLLS          = 4;
	localparam int unsigned SRC_SEL_W         = 4;
	localparam logic [3:0]  SRC_SEL_RST       = 4'h0;
	localparam int unsigned CNT_W             = 16;

	typedef enum logic [4:0] {
		RCS_POR    = 5'h01,
		RCS_HOLD   = 5'h02,
		RCS_PLL    = 5'h04,
		RCS_RESUME = 5'h08,
		RCS_RUN    = 5'h10
	} rcs_state_t;
endpackage

// ==== hw/rcs_sequencer.sv ====
// Purpose: Reset flow sequencer with strap capture and PLL lock waits
// Assumes: Clock inputs arrive as synchronous level samples; one core clock
// Notes:   Input clock periods are counted by their rising edges
`timescale 1ns/1ps
module rcs_sequencer
	import rcs_pkg::*;
#(
	parameter int unsigned PLL_WAIT_CYC = rcs_pkg::PLL_LOCK_CYC
) (
	input  wire logic                           clk,
	input  wire logic                           reset,
	input  wire logic                           clk_en,
	input  wire logic                           host_mode,
	input  wire logic                           primary_clock_in,
	input  wire logic                           pci_sync_clock_in,
	input  wire logic                           power_on_reset_n,
	input  wire logic                           hard_reset_n_in,
	input  wire logic [rcs_pkg::SRC_SEL_W-1:0]  reset_source_strap,
	input  wire logic                           clock_input_divide_strap,
	input  wire logic [rcs_pkg::NUM_PLLS-1:0]   pll_locked,
	output logic                                hard_reset_n_out,
	output logic                                hard_reset_n_oe_n,
	output logic                                strap_oe_n,
	output logic [rcs_pkg::SRC_SEL_W-1:0]       reset_source_q,
	output logic                                clock_div_q,
	output logic                                plls_ready
);
	import rcs_pkg::*;

	rcs_state_t             state_q;
	logic [CNT_W-1:0]       cnt_q;
	logic [16:0]            pll_cnt_q;
	logic                   prim_q, sync_q, host_q;
	logic                   sync_tick, prim_tick, sys_tick;
	logic                   hrst_in_q;
	logic [5:0]             hrst_len_q, por_len_q;
	logic                   div_tog_q;

	// Rising edges of each input clock, in core cycles
	assign prim_tick = primary_clock_in & ~prim_q;
	assign sys_tick  = pci_sync_clock_in & ~sync_q;
	// Host: sync period derived from primary clock and divide strap
	assign sync_tick = host_q ? (prim_tick & (~clock_div_q | div_tog_q)) : sys_tick;

	always_ff @(posedge clk) begin
		if (reset) begin
			prim_q    <= 1'b0;
			sync_q    <= 1'b0;
			div_tog_q <= 1'b0;
			host_q    <= 1'b1;
		end else if (clk_en) begin
			prim_q <= primary_clock_in;
			sync_q <= pci_sync_clock_in;
			if (prim_tick)
				div_tog_q <= ~div_tog_q;
			if (!power_on_reset_n)
				host_q <= host_mode;
		end
	end

	// Qualify input resets by minimum assertion lengths
	always_ff @(posedge clk) begin
		if (reset) begin
			hrst_len_q <= '0;
			por_len_q  <= '0;
			hrst_in_q  <= 1'b0;
		end else if (clk_en) begin
			if (hard_reset_n_in)
				hrst_len_q <= '0;
			else if (sync_tick && hrst_len_q != 6'(HRST_IN_MIN_PER))
				hrst_len_q <= hrst_len_q + 6'h01;
			hrst_in_q <= !hard_reset_n_in && (hrst_len_q == 6'(HRST_IN_MIN_PER));
			if (power_on_reset_n)
				por_len_q <= '0;
			else if ((host_q ? prim_tick : sys_tick) && por_len_q != 6'(POR_MIN_PER))
				por_len_q <= por_len_q + 6'h01;
		end
	end

	// Reset flow state machine
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= RCS_POR;
			cnt_q   <= '0;
		end else if (clk_en) begin
			unique case (state_q)
				RCS_POR: begin
					cnt_q <= '0;
					if (power_on_reset_n && por_len_q == 6'(POR_MIN_PER))
						state_q <= RCS_HOLD;
				end
				RCS_HOLD: begin
					// Count only once the pin is really driven low
					if (sync_tick && !hard_reset_n_oe_n)
						cnt_q <= cnt_q + 16'h0001;
					if (cnt_q >= CNT_W'(HRST_OUT_MIN_PER) && !hrst_in_q) begin
						state_q <= RCS_PLL;
						cnt_q   <= '0;
					end
				end
				RCS_PLL: begin
					if (hrst_in_q)
						state_q <= RCS_HOLD;
					else if (plls_ready) begin
						state_q <= RCS_RESUME;
						cnt_q   <= '0;
					end
				end
				RCS_RESUME: begin
					if (sync_tick)
						cnt_q <= cnt_q + 16'h0001;
					if (hrst_in_q) begin
						state_q <= RCS_HOLD;
						cnt_q   <= '0;
					end else if (cnt_q >= CNT_W'(DRIVE_RESUME_PER))
						state_q <= RCS_RUN;
				end
				RCS_RUN: begin
					cnt_q <= '0;
					if (hrst_in_q)
						state_q <= RCS_HOLD;
				end
			endcase
			if (!power_on_reset_n)
				state_q <= RCS_POR;
		end
	end

	// Straps captured while power-on reset held, frozen on release
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_source_q <= SRC_SEL_RST;
			clock_div_q    <= 1'b0;
		end else if (clk_en && !power_on_reset_n) begin
			reset_source_q <= reset_source_strap;
			clock_div_q    <= clock_input_divide_strap;
		end
	end

	// PLL lock window: each PLL given up to the lock time
	always_ff @(posedge clk) begin
		if (reset) begin
			pll_cnt_q  <= '0;
			plls_ready <= 1'b0;
		end else if (clk_en) begin
			if (state_q != RCS_PLL)
				pll_cnt_q <= '0;
			else if (pll_cnt_q != 17'(PLL_WAIT_CYC))
				pll_cnt_q <= pll_cnt_q + 17'h00001;
			// Ready stays up until the next reset flow
			if (state_q == RCS_POR || state_q == RCS_HOLD)
				plls_ready <= 1'b0;
			else if (state_q == RCS_PLL)
				plls_ready <= (&pll_locked) || (pll_cnt_q == 17'(PLL_WAIT_CYC));
		end
	end

	// Pin drivers
	always_ff @(posedge clk) begin
		if (reset) begin
			hard_reset_n_out  <= 1'b0;
			hard_reset_n_oe_n <= 1'b0;
			strap_oe_n        <= 1'b1;
		end else if (clk_en) begin
			hard_reset_n_out  <= 1'b0;
			hard_reset_n_oe_n <= !(state_q == RCS_POR || state_q == RCS_HOLD);
			strap_oe_n        <= (state_q != RCS_RUN) || hrst_in_q;
		end
	end

	// Checker helpers: sync ticks while pin driven, core cycles with input low
	logic [CNT_W-1:0]       drv_ticks_q;
	logic [6:0]             low_cyc_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			drv_ticks_q <= '0;
			low_cyc_q   <= '0;
		end else if (clk_en) begin
			if (hard_reset_n_oe_n)
				drv_ticks_q <= '0;
			else if (sync_tick && drv_ticks_q != '1)
				drv_ticks_q <= drv_ticks_q + 16'h0001;
			if (hard_reset_n_in)
				low_cyc_q <= '0;
			else if (low_cyc_q != 7'h7f)
				low_cyc_q <= low_cyc_q + 7'h01;
		end
	end

	property p_hold_min;
		@(posedge clk) disable iff (reset)
		(state_q == RCS_HOLD && $past(state_q) != RCS_HOLD) |-> cnt_q == '0;
	endproperty
	a_hold_min: assert property (p_hold_min) else $error("Hold entered with stale count");
	property p_hrst_len;
		@(posedge clk) disable iff (reset)
		$rose(hard_reset_n_oe_n) |-> drv_ticks_q >= CNT_W'(HRST_OUT_MIN_PER);
	endproperty
	a_hrst_len: assert property (p_hrst_len) else $error("Hard reset released early");
	property p_hold_exit;
		@(posedge clk) disable iff (reset)
		($past(state_q) == RCS_HOLD && state_q == RCS_PLL) |-> $past(cnt_q) >= CNT_W'(HRST_OUT_MIN_PER);
	endproperty
	a_hold_exit: assert property (p_hold_exit) else $error("Hold left before count done");
	property p_strap_off;
		@(posedge clk) disable iff (reset)
		!hard_reset_n_oe_n |-> strap_oe_n;
	endproperty
	a_strap_off: assert property (p_strap_off) else $error("Straps driven during reset");
	property p_resume;
		@(posedge clk) disable iff (reset)
		($past(state_q) == RCS_RESUME && state_q == RCS_RUN) |-> $past(cnt_q) >= CNT_W'(DRIVE_RESUME_PER);
	endproperty
	a_resume: assert property (p_resume) else $error("Straps resumed early");
	property p_pll;
		@(posedge clk) disable iff (reset)
		(state_q == RCS_PLL && pll_cnt_q == 17'(PLL_WAIT_CYC) && clk_en) |=> plls_ready || state_q != RCS_PLL;
	endproperty
	a_pll: assert property (p_pll) else $error("PLL wait exceeded");
	property p_straps;
		@(posedge clk) disable iff (reset)
		(power_on_reset_n && $past(power_on_reset_n)) |-> $stable(reset_source_q);
	endproperty
	a_straps: assert property (p_straps) else $error("Straps changed after release");
	property p_por_len;
		@(posedge clk) disable iff (reset)
		($past(state_q) == RCS_POR && state_q == RCS_HOLD) |-> $past(por_len_q) == 6'(POR_MIN_PER);
	endproperty
	a_por_len: assert property (p_por_len) else $error("Short power-on reset accepted");
	property p_hrst_in;
		@(posedge clk) disable iff (reset)
		$rose(hrst_in_q) |-> low_cyc_q >= 7'(2 * HRST_IN_MIN_PER - 1);
	endproperty
	a_hrst_in: assert property (p_hrst_in) else $error("Short hard reset accepted");
	c_run: cover property (@(posedge clk) state_q == RCS_RUN);
	c_rerun: cover property (@(posedge clk) state_q == RCS_RUN ##1 state_q == RCS_HOLD);
	c_pll: cover property (@(posedge clk) state_q == RCS_PLL ##1 state_q == RCS_RESUME);
endmodule // rcs_sequencer

// ==== tb/rcs_board.sv ====
// Purpose: Board side model: input clocks and PLL locks
// Assumes: Clock levels toggle every core cycle
// Notes:   PLLs lock a fixed delay after reset drive ends
`timescale 1ns/1ps
module rcs_board (
	input  wire logic       clk,
	input  wire logic       hard_reset_n_oe_n,
	input  wire logic       lock_hold,
	output logic            primary_clock_in,
	output logic            pci_sync_clock_in,
	output logic [3:0]      pll_locked
);
	int lock_cnt = 0;
	initial begin
		primary_clock_in = 1'b0;
		pci_sync_clock_in = 1'b0;
		pll_locked = 4'h0;
	end
	always @(negedge clk) begin
		primary_clock_in <= ~primary_clock_in;
		pci_sync_clock_in <= ~pci_sync_clock_in;
		lock_cnt <= hard_reset_n_oe_n ? lock_cnt + 1 : 0;
		// Held locks never come, so the sequencer must time out
		pll_locked <= (lock_cnt >= 10 && !lock_hold) ? 4'hf : 4'h0;
	end
endmodule // rcs_board

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the reset sequencer
// Assumes: PLL wait shortened to 20 cycles
// Notes:   One sync tick is 2 or 4 core cycles
`timescale 1ns/1ps
module tb_top;
	import rcs_pkg::*;
	localparam int PLL_WAIT = 20;
	logic clk = 0, reset = 1, host_mode = 0, power_on_reset_n = 0, hard_reset_n_in = 1, lock_hold = 0;
	logic clock_input_divide_strap = 0, pri, syn, oe_n, hr_out, soe_n, div_q, rdy;
	logic [3:0] reset_source_strap = 4'h0, plls, src_q;
	int bad_count = 0, num_checks = 0, cyc = 0, gap = 0;
	always #5 clk = ~clk;
	rcs_board u_board (.clk(clk), .hard_reset_n_oe_n(oe_n), .lock_hold(lock_hold), .primary_clock_in(pri),
		.pci_sync_clock_in(syn), .pll_locked(plls));
	rcs_sequencer #(.PLL_WAIT_CYC(PLL_WAIT)) uut (.clk(clk), .reset(reset), .clk_en(1'b1),
		.host_mode(host_mode), .primary_clock_in(pri), .pci_sync_clock_in(syn),
		.power_on_reset_n(power_on_reset_n), .hard_reset_n_in(hard_reset_n_in),
		.reset_source_strap(reset_source_strap), .clock_input_divide_strap(clock_input_divide_strap),
		.pll_locked(plls), .hard_reset_n_out(hr_out), .hard_reset_n_oe_n(oe_n),
		.strap_oe_n(soe_n), .reset_source_q(src_q), .clock_div_q(div_q), .plls_ready(rdy));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_oe(input logic lvl, inout int n);
		n = 0;
		while (oe_n !== lvl && n < 3000) begin
			if (soe_n !== 1'b1) n = n + 10000;
			@(negedge clk);
			n++;
		end
	endtask
	task automatic por_flow(input logic hm, input logic dv, input logic [3:0] sv, output int m);
		int n, t;
		t = (hm && dv) ? 4 : 2;
		@(negedge clk);
		host_mode = hm;
		clock_input_divide_strap = dv;
		reset_source_strap = sv;
		power_on_reset_n = 0;
		repeat (80) @(negedge clk);
		power_on_reset_n = 1;
		repeat (3) @(negedge clk);
		check({src_q, 3'h0, div_q}, {sv, 3'h0, dv});
		check(16'(hr_out), 16'h0);
		wait_oe(1'b1, n);
		check(16'(n + 3 >= 512 * t), 16'h1);
		check(16'(n + 3 <= 516 * t + 4), 16'h1);
		m = 0;
		while (soe_n !== 1'b0 && m < 60) begin
			@(negedge clk);
			m++;
		end
		check({soe_n, rdy}, 16'h1);
		check(16'(m >= t && m <= 40), 16'h1);
		$display("power-on flow done host=%0d div=%0d", hm, dv);
	endtask
	task automatic hard_reset_flow();
		int n;
		hard_reset_n_in = 0;
		repeat (40) @(negedge clk);
		hard_reset_n_in = 1;
		repeat (20) @(negedge clk);
		check({oe_n, soe_n}, 16'h2);
		hard_reset_n_in = 0;
		n = 0;
		while (oe_n !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check({oe_n, soe_n}, 16'h1);
		check(16'(n >= 60), 16'h1);
		repeat (30) @(negedge clk);
		hard_reset_n_in = 1;
		wait_oe(1'b1, n);
		check(16'(n < 1100), 16'h1);
		$display("hard reset flow done");
	endtask
	task automatic pll_timeout_flow();
		int m;
		lock_hold = 1'b1;
		por_flow(1'b0, 1'b0, 4'h6, m);
		check(16'(m >= PLL_WAIT), 16'h1);
		lock_hold = 1'b0;
		$display("pll timeout flow done");
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		reset = 0;
		por_flow(1'b0, 1'b0, 4'ha, gap);
		hard_reset_flow();
		por_flow(1'b1, 1'b0, 4'h5, gap);
		por_flow(1'b1, 1'b1, 4'h3, gap);
		pll_timeout_flow();
		finish_test();
	end
endmodule // tb_top
